// ==== logic/rbsm_pkg.sv ====
// Functional notes
// RL1 - allocation field is page 0 register 108 bits 6:5, reset value 10
// RL2 - mode 01: one section per channel, sections 1-4 and 9-10 used
// RL3 - mode 10: two cascaded sections on channels 1-6
// RL4 - mode 11: three cascaded sections on channels 1-4
// RL5 - sections 1-6 on page 2, 7-12 on page 3, twenty bytes each from 8
// RL6 - summing field is page 0 register 107 bits 3:2, reset 00 disables
// RL7 - summing 01: outputs 1,2 and 3,4 carry half of pair sums
// RL8 - summing 10: outputs 1-4 carry a quarter of the four-input sum
// RL9 - host never writes summing value 11, it is reserved
// RL10 - mixer acts only while summing field is 00
// RL11 - four mixers over inputs 1-4, mixer n drives output n
// RL12 - mixer coefficients are signed 1.31 words held on page 4
// RL13 - full-scale positive coefficient is unity, smaller values attenuate
// RL14 - zero coefficient mutes that input
// RL15 - negative coefficient keeps magnitude but inverts polarity
// RL16 - allocation field 00 bypasses all sections
// RL17 - host loads coefficients before recording; defaults are flat unity
// RL18 - section is second order: N0, 2N1, N2 over 2^31, 2D1, D2
// RL19 - mixer output is saturated sum of four scaled inputs
// RL20 - cascaded sections run in ascending section order
package rbsm_pkg;
  localparam int DATA_W = 32;
  localparam int CH_N = 8;
  localparam int MIX_N = 4;
  localparam int SEC_N = 12;
  localparam int LVL_N = 3;
  localparam int COEF_N = 5;
  localparam int PIPE_LAT = 4;

  localparam logic [7:0] PG_CFG = 8'h00;
  localparam logic [7:0] PG_BQ_LO = 8'h02;
  localparam logic [7:0] PG_BQ_HI = 8'h03;
  localparam logic [7:0] PG_MIX = 8'h04;
  localparam logic [6:0] REG_SUM = 7'h6B;
  localparam logic [6:0] REG_BIQ = 7'h6C;
  localparam logic [6:0] BQ_BASE = 7'h08;
  localparam logic [6:0] MIX_BASE = 7'h08;
  localparam logic [6:0] MIX_SPAN = 7'h40;
  localparam int SUM_FLD_LSB = 2;
  localparam int BIQ_FLD_LSB = 5;
  localparam int BQ_SPAN = 20;
  localparam int SEC_PER_PAGE = 6;
  localparam int COEF_BYTES = 4;
  localparam int MIX_SPAN_M = 16;

  localparam int K_N0 = 0;
  localparam int K_N1 = 1;
  localparam int K_N2 = 2;
  localparam int K_D1 = 3;
  localparam int K_D2 = 4;

  typedef enum logic [1:0] {
    BQ_OFF = 2'b00,
    BQ_ONE = 2'b01,
    BQ_TWO = 2'b10,
    BQ_THREE = 2'b11
  } rbsm_bq_e;

  typedef enum logic [1:0] {
    SUM_OFF = 2'b00,
    SUM_PAIR = 2'b01,
    SUM_QUAD = 2'b10,
    SUM_RSVD = 2'b11
  } rbsm_sum_e;

  localparam rbsm_bq_e BQ_RST = BQ_TWO;
  localparam rbsm_sum_e SUM_RST = SUM_OFF;
  localparam logic [31:0] COEF_UNITY = 32'h7FFFFFFF;
  localparam logic [31:0] COEF_ZERO = 32'h00000000;

  typedef logic signed [DATA_W-1:0] rbsm_smp_t;

  typedef struct packed {
    logic used;
    logic [1:0] lvl;
    logic [2:0] ch;
  } rbsm_route_s;

  function automatic rbsm_smp_t rbsm_sat(input logic signed [66:0] v);
    if (v > 67'sh7FFFFFFF)
      return 32'sh7FFFFFFF;
    if (v < -67'sh80000000)
      return 32'sh80000000;
    return v[31:0];
  endfunction

  // which cascade level and channel a section serves in a given mode
  function automatic rbsm_route_s rbsm_route(input rbsm_bq_e cfg,
                                             input int s);
    rbsm_route_s r;
    r = '0;
    if (s < 4)
    begin
      r.used = (cfg != BQ_OFF);
      r.ch = 3'(s);
    end
    else if (s < 8)
    begin
      r.used = (cfg == BQ_TWO) || (cfg == BQ_THREE);
      r.lvl = 2'h1;
      r.ch = 3'(s - 4);
    end
    else if (cfg == BQ_THREE)
    begin
      r.used = 1'b1;
      r.lvl = 2'h2;
      r.ch = 3'(s - 8);
    end
    else
    begin
      r.used = (cfg == BQ_TWO) || ((s < 10) && (cfg == BQ_ONE));
      r.lvl = (s < 10) ? 2'h0 : 2'h1;
      r.ch = 3'(4 + (s % 2));
    end
    return r;
  endfunction
endpackage

// ==== logic/rbsm_bq_if.sv ====
interface rbsm_bq_if;
  import rbsm_pkg::*;
  rbsm_smp_t x;
  rbsm_smp_t y;
  logic step;
  logic [COEF_N-1:0][DATA_W-1:0] coef;
  modport sec (input x, input step, input coef, output y);
  modport ctl (output x, output step, output coef, input y);
endinterface

// ==== logic/rbsm_biquad.sv ====
module rbsm_biquad
  import rbsm_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  rbsm_bq_if.sec bq
);
  rbsm_smp_t x1, x2, y1, y2;
  rbsm_smp_t next_x1, next_x2, next_y1, next_y2;
  logic signed [63:0] p [COEF_N];
  logic signed [66:0] acc;

  always_comb
  begin
    p[K_N0] = $signed(bq.coef[K_N0]) * bq.x;
    p[K_N1] = $signed(bq.coef[K_N1]) * x1;
    p[K_N2] = $signed(bq.coef[K_N2]) * x2;
    p[K_D1] = $signed(bq.coef[K_D1]) * y1;
    p[K_D2] = $signed(bq.coef[K_D2]) * y2;
    // y * 2^31 = N0 x + 2 N1 x1 + N2 x2 + 2 D1 y1 + D2 y2
    acc = 67'(p[K_N0]) + (67'(p[K_N1]) <<< 1) + 67'(p[K_N2])
        + (67'(p[K_D1]) <<< 1) + 67'(p[K_D2]); // RL18
    bq.y = rbsm_sat(acc >>> 31);
    next_x1 = x1;
    next_x2 = x2;
    next_y1 = y1;
    next_y2 = y2;
    // history only moves when this section is really in the chain
    if (bq.step)
    begin
      next_x1 = bq.x;
      next_x2 = x1;
      next_y1 = bq.y;
      next_y2 = y1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      x1 <= '0;
      x2 <= '0;
      y1 <= '0;
      y2 <= '0;
    end
    else
    begin
      x1 <= next_x1;
      x2 <= next_x2;
      y1 <= next_y1;
      y2 <= next_y2;
    end
  end
endmodule

// ==== logic/rbsm_mix_lane.sv ====
module rbsm_mix_lane
  import rbsm_pkg::*;
#(
  parameter int N_IN = MIX_N
)
(
  input wire logic [N_IN-1:0][DATA_W-1:0] x_i,
  input wire logic [N_IN-1:0][DATA_W-1:0] coef_i,
  output logic [DATA_W-1:0] y_o
);
  if (N_IN < 1 || N_IN > 8)
    $error("mix lane input count out of range");

  logic signed [66:0] acc;
  logic signed [63:0] prod;

  // two's complement scaling gives mute at zero and inversion when negative
  // full product kept in its own word so no tool narrows the multiply
  always_comb
  begin
    acc = '0;
    prod = '0;
    for (int k = 0; k < N_IN; k++)
    begin
      prod = $signed(coef_i[k]) * $signed(x_i[k]);
      acc = acc + 67'(prod); // RL13 RL14 RL15
    end
    y_o = rbsm_sat(acc >>> 31); // RL19 RL12
  end
endmodule

// ==== logic/rbsm_top.sv ====
module rbsm_top
  import rbsm_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CTRL_WE_I,
  input wire logic [7:0] CTRL_PAGE_I,
  input wire logic [6:0] CTRL_REG_I,
  input wire logic [7:0] CTRL_WDATA_I,
  input wire logic DIN_VALID_I,
  input wire logic [CH_N-1:0][DATA_W-1:0] DIN_I,
  output logic DOUT_VALID_O,
  output logic [CH_N-1:0][DATA_W-1:0] DOUT_O,
  output logic [1:0] BIQ_CFG_O,
  output logic [1:0] CHAN_SUM_SEL_O
);
  rbsm_bq_e biq_cfg, next_biq_cfg;
  rbsm_sum_e chan_sum_sel, next_chan_sum_sel;
  logic [COEF_N-1:0][DATA_W-1:0] bq_coef [SEC_N];
  logic [COEF_N-1:0][DATA_W-1:0] next_bq_coef [SEC_N];
  logic [MIX_N-1:0][MIX_N-1:0][DATA_W-1:0] mix_coef, next_mix_coef;
  logic [6:0] wr_off;
  int wr_sec, wr_k, wr_b;

  rbsm_smp_t st [LVL_N+1][CH_N];
  rbsm_smp_t next_st [LVL_N+1][CH_N];
  logic [LVL_N:0] st_v, next_st_v;
  rbsm_smp_t lvl_y [LVL_N][CH_N];
  rbsm_smp_t sec_y [SEC_N];
  logic [SEC_N-1:0] sec_step;
  rbsm_route_s sec_rt [SEC_N];

  logic [MIX_N-1:0][DATA_W-1:0] mix_x, mix_y;
  logic signed [32:0] pair_a, pair_b;
  logic signed [33:0] quad;
  logic [CH_N-1:0][DATA_W-1:0] next_dout;
  logic next_dout_v;

  // control port: configuration fields and coefficient bytes
  always_comb
  begin
    next_biq_cfg = biq_cfg;
    next_chan_sum_sel = chan_sum_sel;
    next_bq_coef = bq_coef;
    next_mix_coef = mix_coef;
    wr_off = CTRL_REG_I - BQ_BASE;
    wr_sec = 0;
    wr_k = 0;
    wr_b = 0;
    if (CTRL_WE_I && CTRL_PAGE_I == PG_CFG)
    begin
      if (CTRL_REG_I == REG_BIQ)
        next_biq_cfg = rbsm_bq_e'(CTRL_WDATA_I[BIQ_FLD_LSB +: 2]); // RL1
      if (CTRL_REG_I == REG_SUM)
        next_chan_sum_sel =
          rbsm_sum_e'(CTRL_WDATA_I[SUM_FLD_LSB +: 2]); // RL6
    end
    if (CTRL_WE_I && CTRL_REG_I >= BQ_BASE &&
        (CTRL_PAGE_I == PG_BQ_LO || CTRL_PAGE_I == PG_BQ_HI))
    begin
      // coefficient words stored most significant byte first
      wr_sec = int'(wr_off) / BQ_SPAN;
      if (CTRL_PAGE_I == PG_BQ_HI)
        wr_sec = wr_sec + SEC_PER_PAGE;
      wr_k = (int'(wr_off) % BQ_SPAN) / COEF_BYTES;
      wr_b = COEF_BYTES - 1 - (int'(wr_off) % COEF_BYTES);
      next_bq_coef[wr_sec][wr_k][wr_b*8 +: 8] = CTRL_WDATA_I; // RL5
    end
    wr_off = CTRL_REG_I - MIX_BASE;
    if (CTRL_WE_I && CTRL_PAGE_I == PG_MIX && CTRL_REG_I >= MIX_BASE &&
        wr_off < MIX_SPAN)
    begin
      wr_sec = int'(wr_off) / MIX_SPAN_M;
      wr_k = (int'(wr_off) % MIX_SPAN_M) / COEF_BYTES;
      wr_b = COEF_BYTES - 1 - (int'(wr_off) % COEF_BYTES);
      next_mix_coef[wr_sec][wr_k][wr_b*8 +: 8] = CTRL_WDATA_I; // RL12
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      biq_cfg <= BQ_RST; // RL1
      chan_sum_sel <= SUM_RST; // RL6
      // defaults give flat unity sections and a straight-through mixer
      for (int s = 0; s < SEC_N; s++)
      begin
        bq_coef[s] <= '0;
        bq_coef[s][K_N0] <= COEF_UNITY; // RL17
      end
      for (int m = 0; m < MIX_N; m++)
        for (int k = 0; k < MIX_N; k++)
          mix_coef[m][k] <= (m == k) ? COEF_UNITY : COEF_ZERO;
      BIQ_CFG_O <= BQ_RST;
      CHAN_SUM_SEL_O <= SUM_RST;
    end
    else
    begin
      biq_cfg <= next_biq_cfg;
      chan_sum_sel <= next_chan_sum_sel;
      bq_coef <= next_bq_coef;
      mix_coef <= next_mix_coef;
      BIQ_CFG_O <= next_biq_cfg;
      CHAN_SUM_SEL_O <= next_chan_sum_sel;
    end
  end

  // twelve sections, each fed from the stage of its cascade level
  rbsm_bq_if bq_if [SEC_N] ();
  for (genvar g = 0; g < SEC_N; g++)
  begin : g_sec
    assign sec_rt[g] = rbsm_route(biq_cfg, g); // RL2 RL3 RL4
    assign bq_if[g].x = st[sec_rt[g].lvl][sec_rt[g].ch];
    assign bq_if[g].step = sec_rt[g].used & st_v[sec_rt[g].lvl];
    assign bq_if[g].coef = bq_coef[g];
    assign sec_y[g] = bq_if[g].y;
    assign sec_step[g] = bq_if[g].step;
    rbsm_biquad u_bq
    (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .bq(bq_if[g].sec)
    );
  end

  // unallocated channel positions pass through each level untouched
  always_comb
  begin
    for (int l = 0; l < LVL_N; l++)
      for (int c = 0; c < CH_N; c++)
        lvl_y[l][c] = st[l][c]; // RL16
    for (int s = 0; s < SEC_N; s++)
      if (sec_rt[s].used)
        lvl_y[sec_rt[s].lvl][sec_rt[s].ch] = sec_y[s]; // RL20
  end

  // one level per stage keeps ascending section order and fixed latency
  always_comb
  begin
    next_st = st;
    next_st_v = {st_v[LVL_N-1:0], DIN_VALID_I};
    if (DIN_VALID_I)
      for (int c = 0; c < CH_N; c++)
        next_st[0][c] = DIN_I[c];
    for (int l = 0; l < LVL_N; l++)
      if (st_v[l])
        next_st[l+1] = lvl_y[l]; // RL20
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      st_v <= '0;
      for (int l = 0; l <= LVL_N; l++)
        for (int c = 0; c < CH_N; c++)
          st[l][c] <= '0;
    end
    else
    begin
      st_v <= next_st_v;
      st <= next_st;
    end
  end

  for (genvar m = 0; m < MIX_N; m++)
  begin : g_mix
    assign mix_x[m] = st[LVL_N][m];
    rbsm_mix_lane #(.N_IN(MIX_N)) u_mix
    (
      .x_i(mix_x),
      .coef_i(mix_coef[m]),
      .y_o(mix_y[m])
    ); // RL11
  end

  // pair sums are one bit wider and the quad sum two bits, so halving and quartering never overflow
  always_comb
  begin
    pair_a = {st[LVL_N][0][31], st[LVL_N][0]}
           + {st[LVL_N][1][31], st[LVL_N][1]};
    pair_b = {st[LVL_N][2][31], st[LVL_N][2]}
           + {st[LVL_N][3][31], st[LVL_N][3]};
    quad = 34'(pair_a) + 34'(pair_b);
    next_dout = DOUT_O;
    next_dout_v = st_v[LVL_N];
    if (st_v[LVL_N])
    begin
      for (int c = 0; c < CH_N; c++)
        next_dout[c] = st[LVL_N][c];
      unique case (chan_sum_sel)
        SUM_OFF:
        begin
          next_dout[MIX_N-1:0] = mix_y; // RL10
        end
        SUM_PAIR:
        begin
          next_dout[0] = pair_a[32:1]; // RL7
          next_dout[1] = pair_a[32:1];
          next_dout[2] = pair_b[32:1];
          next_dout[3] = pair_b[32:1];
        end
        SUM_QUAD:
        begin
          for (int c = 0; c < MIX_N; c++)
            next_dout[c] = quad[33:2]; // RL8
        end
        SUM_RSVD:
        begin
          // reserved code: samples pass untouched, mixer bypassed
          next_dout[MIX_N-1:0] = next_dout[MIX_N-1:0]; // RL9
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      DOUT_VALID_O <= 1'b0;
      DOUT_O <= '0;
    end
    else
    begin
      DOUT_VALID_O <= next_dout_v;
      DOUT_O <= next_dout;
    end
  end

  chk_alloc_reset: assert property (@(posedge CLK_I) // RL1
    $rose(NRST_I) |-> biq_cfg == BQ_TWO && chan_sum_sel == SUM_OFF)
    else $error("config fields wrong after reset");

  chk_one_unused: assert property (@(posedge CLK_I) // RL2
    disable iff (!NRST_I)
    biq_cfg == BQ_ONE |-> sec_step[7:4] == 4'h0 && sec_step[11:10] == 2'h0)
    else $error("unused section stepped in one-per-channel mode");

  chk_two_level: assert property (@(posedge CLK_I) // RL3
    disable iff (!NRST_I)
    biq_cfg == BQ_TWO && st_v[1] |-> sec_step[11] && sec_step[5]
      && sec_rt[11].ch == 3'h5 && sec_step[8] == st_v[0])
    else $error("second cascade level mis-routed");

  chk_three_level: assert property (@(posedge CLK_I) // RL4
    disable iff (!NRST_I)
    biq_cfg == BQ_THREE |-> sec_step[8] == st_v[2]
      && sec_rt[8].ch == 3'h0)
    else $error("third cascade level mis-routed");

  chk_coef_page3: assert property (@(posedge CLK_I) // RL5
    disable iff (!NRST_I)
    CTRL_WE_I && CTRL_PAGE_I == PG_BQ_HI && CTRL_REG_I == 7'h6C
      |=> bq_coef[11][K_N0][31:24] == $past(CTRL_WDATA_I))
    else $error("page 3 register 108 missed section twelve");

  chk_bypass_all: assert property (@(posedge CLK_I) // RL16
    disable iff (!NRST_I)
    biq_cfg == BQ_OFF && st_v[0] |=> st[1][7] == $past(st[0][7])
      && st[1][0] == $past(st[0][0]))
    else $error("sample altered with sections bypassed");

  chk_sum_pair: assert property (@(posedge CLK_I) // RL7
    disable iff (!NRST_I)
    st_v[LVL_N] && chan_sum_sel == SUM_PAIR |=> DOUT_O[0] == DOUT_O[1]
      && DOUT_O[2] == DOUT_O[3] && DOUT_O[0] == $past(pair_a[32:1]))
    else $error("pair sum output wrong");

  chk_sum_quad: assert property (@(posedge CLK_I) // RL8
    disable iff (!NRST_I)
    st_v[LVL_N] && chan_sum_sel == SUM_QUAD |=> DOUT_O[3] == DOUT_O[0]
      && DOUT_O[0] == $past(quad[33:2]))
    else $error("quad sum output wrong");

  chk_mix_gate: assert property (@(posedge CLK_I) // RL10
    disable iff (!NRST_I)
    st_v[LVL_N] && chan_sum_sel == SUM_OFF
      |=> DOUT_O[MIX_N-1:0] == $past(mix_y))
    else $error("mixer result not on outputs");

  chk_biq_write: assert property (@(posedge CLK_I) // RL1
    disable iff (!NRST_I)
    CTRL_WE_I && CTRL_PAGE_I == PG_CFG && CTRL_REG_I == REG_BIQ
      |=> BIQ_CFG_O == $past(CTRL_WDATA_I[BIQ_FLD_LSB +: 2]))
    else $error("allocation field write not applied");

  chk_sum_write: assert property (@(posedge CLK_I) // RL6
    disable iff (!NRST_I)
    CTRL_WE_I && CTRL_PAGE_I == PG_CFG && CTRL_REG_I == REG_SUM
      |=> CHAN_SUM_SEL_O == $past(CTRL_WDATA_I[SUM_FLD_LSB +: 2]))
    else $error("summing field write not applied");

  chk_coef_page4: assert property (@(posedge CLK_I) // RL12
    disable iff (!NRST_I)
    CTRL_WE_I && CTRL_PAGE_I == PG_MIX && CTRL_REG_I == MIX_BASE
      |=> mix_coef[0][0][31:24] == $past(CTRL_WDATA_I))
    else $error("page 4 register 8 missed first mixer word");

  // valid is registered at the fourth edge, so it is sampled at the fifth
  chk_cascade_lat: assert property (@(posedge CLK_I) // RL20
    disable iff (!NRST_I)
    DIN_VALID_I |-> ##5 DOUT_VALID_O)
    else $error("output valid not four cycles after input");
endmodule

// ==== testbench/rbsm_host.sv ====
module rbsm_host
  import rbsm_pkg::*;
(
  input wire logic clk_i,
  output logic we_o,
  output logic [7:0] page_o,
  output logic [6:0] reg_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    we_o = 1'b0;
    page_o = 8'hFF;
    reg_o = 7'h7F;
    wdata_o = 8'hA5;
  end

  // released lines show the inverse, never a stale copy of the last write
  task automatic wr_byte(input logic [7:0] pg, input logic [6:0] rg,
                         input logic [7:0] d);
    @(negedge clk_i);
    we_o = 1'b1;
    page_o = pg;
    reg_o = rg;
    wdata_o = d;
    @(negedge clk_i);
    we_o = 1'b0;
    page_o = ~pg;
    reg_o = ~rg;
    wdata_o = ~d;
  endtask

  // msb byte at the lowest register
  task automatic wr_word(input logic [7:0] pg, input logic [6:0] rg,
                         input logic [31:0] w);
    for (int i = 0; i < COEF_BYTES; i++)
      wr_byte(pg, rg + 7'(i), w[31 - 8 * i -: 8]);
  endtask

  task automatic set_biq(input logic [1:0] v);
    wr_byte(PG_CFG, REG_BIQ, {1'b0, v, 5'h00});
  endtask

  // reserved encoding is never sent
  task automatic set_sum(input logic [1:0] v);
    if (v != 2'b11)
      wr_byte(PG_CFG, REG_SUM, {4'h0, v, 2'h0});
  endtask
endmodule

// ==== testbench/record_biquad_summer_mixer_bench.sv ====
module record_biquad_summer_mixer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rbsm_pkg::*;

  logic clk;
  logic nrst;
  logic we;
  logic [7:0] page;
  logic [6:0] rg;
  logic [7:0] wdata;
  logic dv;
  logic [CH_N-1:0][DATA_W-1:0] din;
  logic dout_valid;
  logic [CH_N-1:0][DATA_W-1:0] dout;
  logic [CH_N-1:0][DATA_W-1:0] res;
  logic [1:0] biq;
  logic [1:0] sum;
  int mismatches;
  int tests_run;
  logic signed [31:0] mx [4] = '{32'sh40000000, 32'shC0000000,
    32'sh12345678, 32'sh7FFFFFFF};

  rbsm_host i_host (.clk_i(clk), .we_o(we), .page_o(page), .reg_o(rg),
    .wdata_o(wdata));

  rbsm_top i_dut (.CLK_I(clk), .NRST_I(nrst), .CTRL_WE_I(we),
    .CTRL_PAGE_I(page), .CTRL_REG_I(rg), .CTRL_WDATA_I(wdata),
    .DIN_VALID_I(dv), .DIN_I(din), .DOUT_VALID_O(dout_valid),
    .DOUT_O(dout), .BIQ_CFG_O(biq), .CHAN_SUM_SEL_O(sum));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic frame(input logic [CH_N-1:0][DATA_W-1:0] d);
    int k;
    @(negedge clk);
    din = d;
    dv = 1'b1;
    @(negedge clk);
    dv = 1'b0;
    din = ~d;
    for (k = 0; k < 10 && dout_valid !== 1'b1; k++)
      @(negedge clk);
    if (k == 10)
    begin
      mismatches++;
      tally_and_finish();
    end
    check(32'(k), 32'(PIPE_LAT));
    res = dout;
  endtask

  function automatic logic [CH_N-1:0][DATA_W-1:0] stim();
    logic [CH_N-1:0][DATA_W-1:0] v;
    for (int c = 0; c < CH_N; c++)
      v[c] = (c < 4) ? mx[c] : 32'hA0000000 + 32'(c);
    return v;
  endfunction

  task automatic t_reset();
    @(negedge clk);
    check(32'(biq), 32'h00000002);
    check(32'(sum), 32'h00000000);
    $display("reset test done");
  endtask

  // section s halves s times over, so each channel's shift names its chain
  task automatic t_alloc();
    int shf [4][8] = '{'{0, 0, 0, 0, 0, 0, 0, 0},
      '{1, 2, 3, 4, 9, 10, 0, 0}, '{6, 8, 10, 12, 20, 22, 0, 0},
      '{15, 18, 21, 24, 0, 0, 0, 0}};
    logic signed [31:0] e;
    for (int s = 0; s < SEC_N; s++)
      i_host.wr_word((s < 6) ? PG_BQ_LO : PG_BQ_HI,
        BQ_BASE + 7'(BQ_SPAN * (s % 6)), 32'h40000000 >> s);
    for (int m = 0; m < 4; m++)
    begin
      i_host.set_biq(2'(m));
      frame({CH_N{32'hF0000000}});
      check(32'(biq), 32'(m));
      for (int c = 0; c < CH_N; c++)
      begin
        e = 32'shF0000000 >>> shf[m][c];
        check(res[c], e);
      end
    end
    $display("allocation test done");
  endtask

  task automatic t_mixer();
    logic signed [31:0] cf [4][4] = '{
      '{32'sh7FFFFFFF, 32'sh00000000, 32'sh40000000, 32'shC0000000},
      '{32'sh00000000, 32'sh7FFFFFFF, 32'sh00000000, 32'sh00000000},
      '{32'sh7FFFFFFF, 32'sh00000000, 32'sh7FFFFFFF, 32'sh7FFFFFFF},
      '{32'sh80000000, 32'sh7FFFFFFF, 32'sh00000000, 32'sh00000000}};
    logic signed [66:0] acc;
    i_host.set_biq(2'b00);
    for (int m = 0; m < MIX_N; m++)
      for (int k = 0; k < MIX_N; k++)
        i_host.wr_word(PG_MIX, MIX_BASE + 7'(16 * m + 4 * k), cf[m][k]);
    frame(stim());
    for (int m = 0; m < MIX_N; m++)
    begin
      acc = '0;
      for (int k = 0; k < MIX_N; k++)
        acc = acc + mx[k] * cf[m][k];
      acc = acc >>> 31;
      if (acc > 67'sh7FFFFFFF)
        acc = 67'sh7FFFFFFF;
      if (acc < -67'sh80000000)
        acc = -67'sh80000000;
      check(res[m], acc[31:0]);
    end
    for (int c = 4; c < CH_N; c++)
      check(res[c], 32'hA0000000 + 32'(c));
    $display("mixer test done");
  endtask

  task automatic t_summing();
    logic signed [33:0] p;
    logic signed [33:0] q;
    i_host.set_sum(2'b01);
    frame(stim());
    check(32'(sum), 32'h00000001);
    p = mx[0] + mx[1];
    q = mx[2] + mx[3];
    for (int c = 0; c < 4; c++)
      check(res[c], (c < 2) ? p[32:1] : q[32:1]);
    i_host.set_sum(2'b10);
    frame(stim());
    p = mx[0] + mx[1] + mx[2] + mx[3];
    for (int c = 0; c < 4; c++)
      check(res[c], p[33:2]);
    i_host.set_sum(2'b11);
    @(negedge clk);
    check(32'(sum), 32'h00000002);
    $display("summing test done");
  endtask

  // mid-run reset clears history; section 9 then recurses on channel 5
  // all five at 2^29: y = x/4 + x1/2 + x2/4 + y1/2 + y2/4
  task automatic t_recur();
    logic [31:0] exp_y [3] = '{32'h04000000, 32'h0E000000, 32'h18000000};
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check(32'(biq), 32'h00000002);
    check(32'(sum), 32'h00000000);
    for (int k = 0; k < COEF_N; k++)
      i_host.wr_word(PG_BQ_HI, BQ_BASE + 7'(2 * BQ_SPAN + COEF_BYTES * k),
        32'h20000000);
    i_host.set_biq(2'b01);
    for (int n = 0; n < 3; n++)
    begin
      frame({CH_N{32'h10000000}});
      check(res[4], exp_y[n]);
      check(res[5], 32'h0FFFFFFF);
      check(res[6], 32'h10000000);
    end
    $display("recursion test done");
  endtask

  initial
  begin
    mismatches = 0;
    tests_run = 0;
    nrst = 1'b0;
    dv = 1'b0;
    din = '0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_alloc();
    t_mixer();
    t_summing();
    t_recur();
    tally_and_finish();
  end
endmodule
